// File: src/gclkc_pkg.sv
// Package with constants and types for the generic clock controller.
package gclkc_pkg;
	localparam int NUM_GEN = 4;
	localparam int NUM_CH = 8;
	localparam int NUM_SRC = 4;
	localparam int GEN_W = 2;
	localparam int SRC_W = 2;
	localparam int CH_W = 3;

	// Register offsets (byte addresses).
	localparam logic [7:0] MAIN_CONTROL_OFS = 8'h00;
	localparam logic [7:0] STATUS_OFS = 8'h04;
	localparam logic [7:0] GENERATOR_CONTROL_OFS = 8'h20;
	localparam logic [7:0] PERIPHERAL_CHANNEL_CONTROL_OFS = 8'h80;

	// Main control fields.
	localparam int SOFT_RESET_BIT_POS = 0;
	localparam int STANDBY_POS = 1;

	// Generator control fields.
	localparam int GEN_SRC_LSB = 0;
	localparam int GEN_ENABLE_POS = 8;
	localparam int GEN_OE_POS = 11;
	localparam int RUN_IN_STANDBY_BIT_POS = 13;

	// Peripheral channel control fields.
	localparam int CH_GEN_LSB = 0;
	localparam int CHANNEL_ENABLE_BIT_POS = 6;
	localparam int WRITE_LOCK_BIT_POS = 7;

	// Reset values; generator 0 and channel 0 run straight after reset.
	localparam logic [31:0] GEN0_RESET_VAL = 32'h0000_0100;
	localparam logic [31:0] GENX_RESET_VAL = 32'h0000_0000;
	localparam logic [31:0] CH0_RESET_VAL = 32'h0000_0040;
	localparam logic [31:0] CHX_RESET_VAL = 32'h0000_0000;

	// Source wake settle time in cycles.
	localparam logic [3:0] SRC_WAKE_CYCLES = 4'h4;

	typedef enum logic [1:0] {
		GCLKC_IDLE = 2'b00,
		GCLKC_WAKE = 2'b01,
		GCLKC_GEN = 2'b11,
		GCLKC_CHAN = 2'b10
	} gclkc_state_e;

	// Picks the generator field of a channel control word.
	function automatic logic [1:0] gclkc_gen_of(input logic [31:0] ch);
		return ch[CH_GEN_LSB +: 2];
	endfunction : gclkc_gen_of
endpackage : gclkc_pkg

// File: src/gclkc_cfg_if.sv
// Interface carrying the configuration words between the register file and the sequencer.
`timescale 1ns/1ps
interface gclkc_cfg_if;
	logic [31:0] gen_cfg [gclkc_pkg::NUM_GEN];
	logic [31:0] ch_cfg [gclkc_pkg::NUM_CH];
	logic [gclkc_pkg::NUM_SRC-1:0] src_on;
	logic [gclkc_pkg::NUM_CH-1:0] ch_run;
	logic [gclkc_pkg::NUM_GEN-1:0] gen_run;
	logic standby;

	modport regs (output gen_cfg, output ch_cfg, output standby, input src_on);
	modport seq (input gen_cfg, input ch_cfg, input standby, output src_on, output ch_run,
		output gen_run);
endinterface : gclkc_cfg_if

// File: src/gclkc_seq.sv
// On-demand request sequencer: wakes the source, then generator, then channel.
`timescale 1ns/1ps
module gclkc_seq (
	// Clock and reset.
	input  wire logic                         ref_clk,
	input  wire logic                         rst_n,
	// Synchronised peripheral requests.
	input  wire logic [gclkc_pkg::NUM_CH-1:0] req,
	// Configuration and run state.
	gclkc_cfg_if.seq                          cfg
);
	gclkc_pkg::gclkc_state_e state_q;
	logic [gclkc_pkg::CH_W-1:0] ch_q;
	logic [3:0] cnt_q;
	logic [gclkc_pkg::NUM_CH-1:0] grant_q;
	logic [gclkc_pkg::NUM_GEN-1:0] gen_req;
	logic [gclkc_pkg::NUM_SRC-1:0] src_d;
	logic [gclkc_pkg::NUM_GEN-1:0] gen_act;
	logic [1:0] g;

	assign g = gclkc_pkg::gclkc_gen_of(cfg.ch_cfg[ch_q]);

	always_comb begin
		gen_req = '0;
		gen_act = '0;
		src_d = '0;
		for (int c = 0; c < gclkc_pkg::NUM_CH; c++) begin
			if (req[c] && grant_q[c]) begin
				gen_req[gclkc_pkg::gclkc_gen_of(cfg.ch_cfg[c])] = 1'b1;
			end
		end
		for (int n = 0; n < gclkc_pkg::NUM_GEN; n++) begin
			if (!cfg.standby) begin
				gen_act[n] = cfg.gen_cfg[n][gclkc_pkg::GEN_ENABLE_POS];
			end else begin
				gen_act[n] = gen_req[n] | (cfg.gen_cfg[n][gclkc_pkg::RUN_IN_STANDBY_BIT_POS]
					& cfg.gen_cfg[n][gclkc_pkg::GEN_OE_POS]);
			end
			if (gen_act[n]) begin
				src_d[cfg.gen_cfg[n][gclkc_pkg::GEN_SRC_LSB +: 2]] = 1'b1;
			end
		end
		if (state_q != gclkc_pkg::GCLKC_IDLE) begin
			src_d[cfg.gen_cfg[g][gclkc_pkg::GEN_SRC_LSB +: 2]] = 1'b1;
		end
	end

	assign cfg.src_on = src_d;
	assign cfg.gen_run = gen_act;

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			cfg.ch_run <= '0;
		end else begin
			for (int c = 0; c < gclkc_pkg::NUM_CH; c++) begin
				cfg.ch_run[c] <= cfg.ch_cfg[c][gclkc_pkg::CHANNEL_ENABLE_BIT_POS] &
					(cfg.standby ? (req[c] & grant_q[c]) : 1'b1) &
					gen_act[gclkc_pkg::gclkc_gen_of(cfg.ch_cfg[c])];
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			state_q <= gclkc_pkg::GCLKC_IDLE;
			ch_q <= '0;
			cnt_q <= '0;
			grant_q <= '0;
		end else begin
			grant_q <= grant_q & req;
			case (state_q)
				gclkc_pkg::GCLKC_IDLE: begin
					// Ascending scan: the last match, the highest index, wins.
					for (int c = 0; c < gclkc_pkg::NUM_CH; c++) begin
						if (req[c] && !grant_q[c] && cfg.standby) begin
							ch_q <= c[gclkc_pkg::CH_W-1:0];
							state_q <= gclkc_pkg::GCLKC_WAKE;
							cnt_q <= '0;
						end
					end
				end
				gclkc_pkg::GCLKC_WAKE: begin
					cnt_q <= cnt_q + 4'h1;
					if (cnt_q == gclkc_pkg::SRC_WAKE_CYCLES) begin
						state_q <= gclkc_pkg::GCLKC_GEN;
					end
				end
				gclkc_pkg::GCLKC_GEN: begin
					state_q <= gclkc_pkg::GCLKC_CHAN;
				end
				gclkc_pkg::GCLKC_CHAN: begin
					grant_q[ch_q] <= 1'b1;
					state_q <= gclkc_pkg::GCLKC_IDLE;
				end
				default: begin
					state_q <= gclkc_pkg::GCLKC_IDLE;
				end
			endcase
		end
	end
endmodule : gclkc_seq

// File: src/gclkc_top.sv
// Generic clock controller top: Wishbone register file, reset handling and pin output.
//
// Chosen here: the Wishbone interface to the registers and the register offsets.
`timescale 1ns/1ps
module gclkc_top (
	// Clock and reset.
	input  wire logic                         ref_clk,
	input  wire logic                         rst_n,
	input  wire logic                         ext_reset,
	// Wishbone slave.
	input  wire logic                         wb_cyc_i,
	input  wire logic                         wb_stb_i,
	input  wire logic                         wb_we_i,
	input  wire logic [7:0]                   wb_adr_i,
	input  wire logic [3:0]                   wb_sel_i,
	input  wire logic [31:0]                  wb_dat_i,
	output logic      [31:0]                  wb_dat_o,
	output logic                              wb_ack_o,
	// Peripheral clock requests and grants.
	input  wire logic [gclkc_pkg::NUM_CH-1:0] clk_req,
	output logic      [gclkc_pkg::NUM_CH-1:0] ch_clk_en,
	output logic      [gclkc_pkg::NUM_GEN-1:0] gen_clk_en,
	output logic      [gclkc_pkg::NUM_SRC-1:0] src_wake,
	// Clock output pins, one per generator.
	output logic      [gclkc_pkg::NUM_GEN-1:0] clock_output_pin_oe
);
	gclkc_cfg_if cfg ();

	logic [31:0] gen_q [gclkc_pkg::NUM_GEN];
	logic [31:0] ch_q [gclkc_pkg::NUM_CH];
	logic [gclkc_pkg::NUM_CH-1:0] ext_off_q;
	logic [gclkc_pkg::NUM_CH-1:0] req_s1_q;
	logic [gclkc_pkg::NUM_CH-1:0] req_s2_q;
	logic ext_s1_q;
	logic ext_s2_q;
	logic ext_d_q;
	logic ext_pulse;
	logic standby_q;
	logic soft_rst;
	logic wr;
	logic hit_gen;
	logic hit_ch;
	logic [2:0] idx;
	logic [31:0] rd_d;

	// Two-stage synchronisers for pin inputs.
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			req_s1_q <= '0;
			req_s2_q <= '0;
			ext_s1_q <= 1'b0;
			ext_s2_q <= 1'b0;
			ext_d_q <= 1'b0;
		end else begin
			req_s1_q <= clk_req;
			req_s2_q <= req_s1_q;
			ext_s1_q <= ext_reset;
			ext_s2_q <= ext_s1_q;
			ext_d_q <= ext_s2_q;
		end
	end
	assign ext_pulse = ext_s2_q & ~ext_d_q;

	assign wr = wb_cyc_i & wb_stb_i & wb_we_i & ~wb_ack_o;
	assign idx = wb_adr_i[4:2];
	assign hit_gen = (wb_adr_i >= gclkc_pkg::GENERATOR_CONTROL_OFS) &&
		(wb_adr_i < gclkc_pkg::GENERATOR_CONTROL_OFS + 8'h10);
	assign hit_ch = (wb_adr_i >= gclkc_pkg::PERIPHERAL_CHANNEL_CONTROL_OFS) &&
		(wb_adr_i < gclkc_pkg::PERIPHERAL_CHANNEL_CONTROL_OFS + 8'h20);
	assign soft_rst = wr && wb_adr_i == gclkc_pkg::MAIN_CONTROL_OFS && wb_sel_i[0] &&
		wb_dat_i[gclkc_pkg::SOFT_RESET_BIT_POS];

	// Byte-lane merge of a write.
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] sel);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++) begin
			if (sel[b]) begin
				r[8*b +: 8] = nw[8*b +: 8];
			end
		end
		return r;
	endfunction : merge

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			standby_q <= 1'b0;
		end else if (soft_rst) begin
			standby_q <= 1'b0;
		end else if (wr && wb_adr_i == gclkc_pkg::MAIN_CONTROL_OFS && wb_sel_i[0]) begin
			standby_q <= wb_dat_i[gclkc_pkg::STANDBY_POS];
		end
	end

	// Generator control words.
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			gen_q[0] <= gclkc_pkg::GEN0_RESET_VAL;
			for (int n = 1; n < gclkc_pkg::NUM_GEN; n++) begin
				gen_q[n] <= gclkc_pkg::GENX_RESET_VAL;
			end
		end else begin
			for (int n = 0; n < gclkc_pkg::NUM_GEN; n++) begin
				if (n == 0 && (soft_rst || ext_pulse)) begin
					gen_q[0] <= gclkc_pkg::GEN0_RESET_VAL;
				end else if (ext_pulse) begin
					gen_q[n][gclkc_pkg::GEN_ENABLE_POS] <= 1'b0;
				end else if (soft_rst && !gen_locked(n)) begin
					gen_q[n] <= gclkc_pkg::GENX_RESET_VAL;
				end else if (wr && hit_gen && idx == 3'(n) && !gen_locked(n)) begin
					gen_q[n] <= merge(gen_q[n], wb_dat_i, wb_sel_i);
				end
			end
		end
	end

	// A generator other than 0 is locked when any channel fed by it holds the lock bit.
	function automatic logic gen_locked(input int n);
		logic l;
		l = 1'b0;
		if (n != 0) begin
			for (int c = 0; c < gclkc_pkg::NUM_CH; c++) begin
				if (ch_q[c][gclkc_pkg::WRITE_LOCK_BIT_POS] &&
					gclkc_pkg::gclkc_gen_of(ch_q[c]) == 2'(n)) begin
					l = 1'b1;
				end
			end
		end
		return l;
	endfunction : gen_locked

	// Peripheral channel control words.
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			ch_q[0] <= gclkc_pkg::CH0_RESET_VAL;
			for (int c = 1; c < gclkc_pkg::NUM_CH; c++) begin
				ch_q[c] <= gclkc_pkg::CHX_RESET_VAL;
			end
			ext_off_q <= '0;
		end else begin
			for (int c = 0; c < gclkc_pkg::NUM_CH; c++) begin
				if (ext_pulse) begin
					ext_off_q[c] <= ch_q[c][gclkc_pkg::CHANNEL_ENABLE_BIT_POS] |
						ext_off_q[c];
					ch_q[c][gclkc_pkg::CHANNEL_ENABLE_BIT_POS] <= 1'b0;
				end else if (ext_off_q[c] &&
					gen_q[gclkc_pkg::gclkc_gen_of(ch_q[c])][gclkc_pkg::GEN_ENABLE_POS]) begin
					ext_off_q[c] <= 1'b0;
					ch_q[c][gclkc_pkg::CHANNEL_ENABLE_BIT_POS] <= 1'b1;
				end else if (ch_q[c][gclkc_pkg::WRITE_LOCK_BIT_POS] &&
					gclkc_pkg::gclkc_gen_of(ch_q[c]) != 2'h0) begin
					ch_q[c] <= ch_q[c];
				end else if (soft_rst) begin
					// Soft reset restores each channel's own start-up word.
					ch_q[c] <= (c == 0) ? gclkc_pkg::CH0_RESET_VAL : gclkc_pkg::CHX_RESET_VAL;
					ext_off_q[c] <= 1'b0;
				end else if (wr && hit_ch && idx == 3'(c)) begin
					ch_q[c] <= merge(ch_q[c], wb_dat_i, wb_sel_i);
				end
			end
		end
	end

	always_comb begin
		for (int n = 0; n < gclkc_pkg::NUM_GEN; n++) begin
			cfg.gen_cfg[n] = gen_q[n];
		end
		for (int c = 0; c < gclkc_pkg::NUM_CH; c++) begin
			cfg.ch_cfg[c] = ch_q[c];
		end
		cfg.standby = standby_q;
	end

	gclkc_seq u_seq (
		.ref_clk (ref_clk),
		.rst_n   (rst_n),
		.req     (req_s2_q),
		.cfg     (cfg)
	);

	always_comb begin
		rd_d = 32'h0000_0000;
		if (wb_adr_i == gclkc_pkg::MAIN_CONTROL_OFS) begin
			rd_d[gclkc_pkg::STANDBY_POS] = standby_q;
		end else if (wb_adr_i == gclkc_pkg::STATUS_OFS) begin
			rd_d = {16'h0000, cfg.src_on, cfg.gen_run, cfg.ch_run};
		end else if (hit_gen) begin
			rd_d = gen_q[idx[1:0]];
		end else if (hit_ch) begin
			rd_d = ch_q[idx];
		end
	end

	// Single-wait-state slave; unmapped reads return zero, writes are dropped.
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0000_0000;
		end else begin
			wb_ack_o <= wb_cyc_i & wb_stb_i & ~wb_ack_o;
			wb_dat_o <= rd_d;
		end
	end

	assign ch_clk_en = cfg.ch_run;
	assign gen_clk_en = cfg.gen_run;
	assign src_wake = cfg.src_on;

	// Clock output pin drive.
	always_comb begin
		for (int n = 0; n < gclkc_pkg::NUM_GEN; n++) begin
			clock_output_pin_oe[n] = gen_q[n][gclkc_pkg::GEN_OE_POS] & cfg.gen_run[n] &
				(~standby_q | gen_q[n][gclkc_pkg::RUN_IN_STANDBY_BIT_POS]);
		end
	end
endmodule : gclkc_top

// File: tb/gclkc_top_properties.sv
// Checker for the generic clock controller top ports.
`timescale 1ns/1ps
module gclkc_top_properties (
	// Clock and reset.
	input wire logic       ref_clk,
	input wire logic       rst_n,
	input wire logic       ext_reset,
	// Bus handshake.
	input wire logic       wb_cyc_i,
	input wire logic       wb_stb_i,
	input wire logic       wb_ack_o,
	// Clock delivery.
	input wire logic [7:0] ch_clk_en,
	input wire logic [3:0] gen_clk_en,
	input wire logic [3:0] src_wake,
	input wire logic [3:0] clock_output_pin_oe
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_n);

	chk_ack_follows_req: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("ack missing after request");
	chk_ack_one_cycle: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack longer than one cycle");
	chk_ack_has_cause: assert property (wb_ack_o |-> $past(wb_stb_i))
		else $error("ack without request");
	chk_ch0_after_reset: assert property ($rose(rst_n) |-> ##[0:2] ch_clk_en[0])
		else $error("channel 0 not running after reset");
	chk_pin_needs_gen: assert property ((clock_output_pin_oe & ~gen_clk_en) == 4'h0)
		else $error("pin driven by an idle generator");
	chk_gen_before_chan: assert property ((ch_clk_en & ~$past(ch_clk_en)) != 8'h0
		|-> $past(gen_clk_en) != 4'h0)
		else $error("channel started before generator");
	chk_ext_reset_gens: assert property ($rose(ext_reset)
		|-> ##[3:8] gen_clk_en[3:1] == 3'h0)
		else $error("generators still on after external reset");
	chk_wake_then_gen: assert property ((src_wake & ~$past(src_wake)) != 4'h0
		|-> ##[1:8] gen_clk_en != 4'h0)
		else $error("no generator after source wake");

	cov_ext_reset: cover property ($rose(ext_reset));
	cov_grant: cover property ($rose(ch_clk_en[2]));
	cov_pin: cover property (clock_output_pin_oe[2]);
endmodule : gclkc_top_properties

// File: tb/gclkc_periph_model.sv
// Peripherals that ask for their generic clock while asleep.
`timescale 1ns/1ps
module gclkc_periph_model (
	// Clock and reset.
	input  wire logic       ref_clk,
	input  wire logic       rst_n,
	// Bench command and controller grant.
	input  wire logic [7:0] start,
	input  wire logic [7:0] ch_clk_en,
	output logic      [7:0] clk_req
);
	logic [2:0] run_q [8];
	always_ff @(posedge ref_clk) begin
		for (int k = 0; k < 8; k++) begin
			if (!rst_n) begin
				clk_req[k] <= 1'h0;
				run_q[k] <= 3'h0;
			end else if (start[k]) begin
				clk_req[k] <= 1'h1;
				run_q[k] <= 3'h0;
			end else if (clk_req[k] && ch_clk_en[k]) begin
				run_q[k] <= run_q[k] + 3'h1;
				clk_req[k] <= (run_q[k] != 3'h3);
			end
		end
	end
endmodule : gclkc_periph_model

// File: tb/tb.sv
// Self-checking bench for the generic clock controller.
`timescale 1ns/1ps
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin err_count++; \
	$display("CHECK FAILED %s exp %h got %h", n, e, g); end end
module tb;
	logic        ref_clk = 1'h0;
	logic        rst_n = 1'h0;
	logic        ext_reset = 1'h0;
	logic        cyc = 1'h0;
	logic        we = 1'h0;
	logic [7:0]  adr = 8'h0;
	logic [31:0] wdat = 32'h0;
	logic [31:0] rdat;
	logic [31:0] dat_o;
	logic        ack;
	logic [7:0]  start = 8'h0;
	logic [7:0]  req;
	logic [7:0]  ch_en;
	logic [3:0]  gen_en;
	logic [3:0]  wake;
	logic [3:0]  pin_oe;
	logic [1:0]  s;
	int          err_count = 0;
	int          checks_done = 0;
	int          t;
	int          sw;
	int          sg;
	int unsigned rng = 15;
	int          g_m [4];
	int          c_m [8];
	bit          pend [8];

	always #10 ref_clk = ~ref_clk;

	gclkc_top i_dut (.ref_clk, .rst_n, .ext_reset, .wb_cyc_i(cyc), .wb_stb_i(cyc),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(dat_o),
		.wb_ack_o(ack), .clk_req(req), .ch_clk_en(ch_en), .gen_clk_en(gen_en),
		.src_wake(wake), .clock_output_pin_oe(pin_oe));
	gclkc_periph_model i_per (.ref_clk, .rst_n, .start, .ch_clk_en(ch_en), .clk_req(req));

	function automatic int unsigned xs(input int unsigned v);
		v ^= v << 13;
		v ^= v >> 17;
		v ^= v << 5;
		return v;
	endfunction : xs

	function automatic bit locked(input int g);
		locked = 0;
		for (int m = 0; m < 8; m++) if (c_m[m][7] && c_m[m][1:0] == g) locked = 1;
	endfunction : locked

	task automatic print_verdict;
		$display("checks %0d mismatches %0d", checks_done, err_count);
		if (err_count == 0 && checks_done > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : print_verdict

	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge ref_clk);
		cyc <= 1'h1;
		we <= w;
		adr <= a;
		wdat <= d;
		n = 0;
		do begin
			@(posedge ref_clk);
			n++;
		end while (ack !== 1'h1 && n < 20);
		rdat = dat_o;
		cyc <= 1'h0;
		if (n >= 20) begin
			err_count++;
			print_verdict();
		end
	endtask : bus

	task automatic rc(input logic [7:0] a, input int e);
		bus(1'h0, a, 32'h0);
		`CHK("register", e[31:0], rdat)
	endtask : rc

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		bus(1'h1, a, d);
		if (a[7:4] == 4'h2 && (a == 8'h20 || !locked(a[3:2]))) begin
			g_m[a[3:2]] = d & 32'h2903;
			for (int m = 0; m < 8; m++) if (d[8] && pend[m] && c_m[m][1:0] == a[3:2]) begin
				c_m[m] |= 64;
				pend[m] = 0;
			end
		end
		if (a[7:5] == 3'h4 && (!c_m[a[4:2]][7] || c_m[a[4:2]][1:0] == 0))
			c_m[a[4:2]] = d & 32'hC3;
		if (a == 8'h00 && d[0]) begin
			g_m[0] = 256;
			for (int g = 1; g < 4; g++) if (!locked(g)) g_m[g] = 0;
			for (int m = 0; m < 8; m++) if (!c_m[m][7] || c_m[m][1:0] == 0) c_m[m] = m ? 0 : 64;
		end
	endtask : wr

	initial begin
		for (int i = 0; i < 4; i++) g_m[i] = i ? 0 : 256;
		for (int i = 0; i < 8; i++) c_m[i] = i ? 0 : 64;
		repeat (16) @(posedge ref_clk);
		rst_n <= 1'h1;
		for (int i = 0; i < 4; i++) rc(8'(32 + 4 * i), g_m[i]);
		for (int i = 0; i < 8; i++) rc(8'(128 + 4 * i), c_m[i]);
		rc(8'h10, 0);
		$display("test reset values done");
		rng = xs(rng);
		wr(8'h84, 32'h81);
		wr(8'h24, 32'h101);
		wr(8'h84, 32'h0);
		wr(8'h20, 32'h100 | rng[1:0]);
		rc(8'h24, g_m[1]);
		rc(8'h84, c_m[1]);
		rc(8'h20, g_m[0]);
		wr(8'h00, 32'h1);
		rc(8'h84, c_m[1]);
		rc(8'h20, g_m[0]);
		$display("test lock done");
		rng = xs(rng);
		s = rng[1:0];
		wr(8'h28, 32'h100 | s);
		wr(8'h88, 32'h42);
		wr(8'h00, 32'h2);
		start <= 8'h04;
		@(posedge ref_clk);
		start <= 8'h0;
		sw = -1;
		sg = -1;
		for (t = 0; t < 40 && ch_en[2] !== 1'h1; t++) begin
			@(posedge ref_clk);
			if (wake[s] === 1'h1 && sw < 0) sw = t;
			if (gen_en[2] === 1'h1 && sg < 0) sg = t;
		end
		`CHK("grant", c_m[2][6] & g_m[2][8], ch_en[2])
		`CHK("wake order", 1'h1, sw >= 0 && sw <= sg)
		`CHK("gen order", 1'h1, sg >= 0 && sg < t)
		if (t >= 40) begin
			err_count++;
			print_verdict();
		end
		repeat (20) @(posedge ref_clk);
		wr(8'h28, 32'h2900 | s);
		repeat (4) @(posedge ref_clk);
		`CHK("pin on", g_m[2][13] & g_m[2][11], pin_oe[2])
		wr(8'h28, 32'h0900 | s);
		repeat (4) @(posedge ref_clk);
		`CHK("pin off", g_m[2][13] & g_m[2][11], pin_oe[2])
		$display("test standby done");
		wr(8'h00, 32'h0);
		wr(8'h28, 32'h100 | s);
		ext_reset <= 1'h1;
		repeat (8) @(posedge ref_clk);
		ext_reset <= 1'h0;
		repeat (4) @(posedge ref_clk);
		g_m[0] = 256;
		for (int g = 1; g < 4; g++) g_m[g] &= ~256;
		for (int m = 0; m < 8; m++) begin
			pend[m] = c_m[m][6] && c_m[m][1:0] != 0;
			if (pend[m]) c_m[m] &= ~64;
		end
		`CHK("chan off", 1'h0, ch_en[2])
		rc(8'h88, c_m[2]);
		rc(8'h28, g_m[2]);
		wr(8'h28, 32'h100 | s);
		repeat (4) @(posedge ref_clk);
		rc(8'h88, c_m[2]);
		`CHK("chan back", 1'h1, ch_en[2])
		$display("test external reset done");
		print_verdict();
	end
endmodule : tb

bind gclkc_top gclkc_top_properties i_chk (.ref_clk, .rst_n, .ext_reset, .wb_cyc_i,
	.wb_stb_i, .wb_ack_o, .ch_clk_en, .gen_clk_en, .src_wake, .clock_output_pin_oe);
